// ---- logic/mpu_region_checker.sv ----
// protection unit top: avalon-mm register slave plus access checker
// assumes access requests from core logic on the same clock
`timescale 1ns/1ps
`include "mpu_map.svh"
module mpu_region_checker (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  input  wire logic [11:0] i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  input  wire logic [3:0]  i_byteenable,
  output logic [31:0]      o_readdata,
  output logic             o_waitrequest,
  input  wire logic        i_acc_valid,
  input  wire logic [31:0] i_acc_addr,
  input  wire logic        i_acc_write,
  input  wire logic        i_acc_fetch,
  input  wire logic        i_acc_priv,
  output logic             o_acc_done,
  output logic             o_fault,
  output logic [2:0]       o_region
);
  typedef struct packed {
    mpu_pkg::region_type [7:0] region;
    logic [2:0]  sel;
    logic        unit_en;
    logic        bgnd_en;
    logic        ack;
    logic [31:0] rdata;
    logic        done;
    logic        fault;
    logic [2:0]  hit_region;
    logic [7:0]  cause;
    logic [31:0] fault_addr;
  } state_type;

  state_type s;
  state_type next_s;
  mpu_check_if chk ();
  mpu_pkg::match_type m;
  mpu_pkg::mem_kind_type kind;

  for (genvar g = 0; g < 8; g++) begin : g_map
    assign chk.regions[g] = s.region[g];
  end
  assign chk.unit_enable = s.unit_en;
  assign chk.bgnd_enable = s.bgnd_en;

  mpu_region_match u_match (
    .bus     (chk),
    .i_addr  (i_acc_addr),
    .o_match (m)
  );

  mpu_attr_decode u_attr (
    .i_type_extension (s.region[m.number].type_extension),
    .i_cacheable      (s.region[m.number].cacheable),
    .i_bufferable     (s.region[m.number].bufferable),
    .i_shareable      (s.region[m.number].shareable),
    .o_kind           (kind),
    .o_shared         (),
    .o_inner          (),
    .o_outer          ()
  );

  // permission lookup; 100 is reserved and treated as no access
  function automatic logic allowed(input logic [2:0] ap,
                                   input logic priv, input logic wr);
    case (ap)
      3'h1:    allowed = priv;
      3'h2:    allowed = priv | ~wr;
      3'h3:    allowed = 1'b1;
      3'h5:    allowed = priv & ~wr;
      3'h6,
      3'h7:    allowed = ~wr;
      default: allowed = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] pack_attr(input mpu_pkg::region_type r);
    pack_attr = {3'h0, r.exec_never, 1'h0, r.access_permission, 2'h0,
                 r.type_extension, r.shareable, r.cacheable, r.bufferable,
                 r.sub_mask, 2'h0, r.size, r.enable};
  endfunction

  logic        alias_hit;
  logic [2:0]  alias_idx;
  logic        is_base;
  logic [11:0] rel;
  logic        perm_ok;
  logic        bg_ok;
  assign rel       = i_address - `MPU_OFS_BASE;
  assign alias_hit = (i_address >= `MPU_OFS_BASE) &&
                     (i_address <= `MPU_OFS_ALIAS_END) &&
                     (i_address[1:0] == 2'h0);
  assign is_base   = (rel[2] == 1'b0);
  assign alias_idx = 3'(rel >> 3);
  assign perm_ok   = allowed(m.access_permission, i_acc_priv, i_acc_write)
                     && !(i_acc_fetch && m.exec_never);
  assign bg_ok     = i_acc_priv && s.bgnd_en;
  // handshake is combinational: one wait cycle, then ack
  assign o_waitrequest = (i_read | i_write) & ~s.ack;
  assign o_readdata    = s.rdata;
  assign o_acc_done    = s.done;
  assign o_fault       = s.fault;
  assign o_region      = s.hit_region;

  always_comb begin
    logic [2:0]  r;
    logic [31:0] wd;
    r      = 3'h0;
    wd     = i_writedata;
    next_s = s;
    next_s.ack  = 1'b0;
    next_s.done = 1'b0;
    // writes act only on the acknowledge edge, one at a time in bus
    // order, so a burst is just consecutive accepted words
    if ((i_read | i_write) && !s.ack) begin
      next_s.ack = 1'b1;
      r = s.sel + alias_idx;
      if (i_read) begin
        next_s.rdata = 32'h0;
        if (i_address == `MPU_OFS_CTRL)
          next_s.rdata = {29'h0, s.bgnd_en, 1'b0, s.unit_en};
        else if (i_address == `MPU_OFS_SELECT)
          next_s.rdata = {29'h0, s.sel};
        else if (i_address == `MPU_OFS_FAULT)
          next_s.rdata = {24'h0, s.cause};
        else if (i_address == `MPU_OFS_FADDR)
          next_s.rdata = s.fault_addr;
        else if (alias_hit && is_base)
          next_s.rdata = {s.region[r].base, 2'h0, r};
        else if (alias_hit)
          next_s.rdata = pack_attr(s.region[r]);
      end else begin
        if (i_address == `MPU_OFS_CTRL) begin
          next_s.unit_en = wd[`MPU_CTRL_ENABLE];
          next_s.bgnd_en = wd[`MPU_CTRL_BGND];
        end else if (i_address == `MPU_OFS_SELECT) begin
          next_s.sel = wd[2:0];
        end else if (i_address == `MPU_OFS_FAULT) begin
          next_s.cause = s.cause & ~wd[7:0];
        end else if (alias_hit && is_base) begin
          if (wd[`MPU_BASE_VALID]) begin
            r = wd[2:0];
            next_s.sel = wd[2:0];
          end
          next_s.region[r].base = wd[31:5];
        end else if (alias_hit) begin
          // byte lanes: 0 size/enable, 1 subregion mask, 2 cache attributes, 3 ap/xn
          if (i_byteenable[0]) begin
            next_s.region[r].enable = wd[0];
            next_s.region[r].size   = wd[5:1];
          end
          if (i_byteenable[1])
            next_s.region[r].sub_mask = wd[15:8];
          if (i_byteenable[2]) begin
            next_s.region[r].bufferable     = wd[16];
            next_s.region[r].cacheable      = wd[17];
            next_s.region[r].shareable      = wd[18];
            next_s.region[r].type_extension = wd[21:19];
          end
          if (i_byteenable[3]) begin
            next_s.region[r].access_permission = wd[26:24];
            next_s.region[r].exec_never        = wd[28];
          end
        end
      end
    end
    // cache/share attributes never gate an access, only permissions
    if (i_acc_valid) begin
      next_s.done       = 1'b1;
      next_s.hit_region = m.number;
      next_s.fault      = 1'b0;
      if (s.unit_en) begin
        if (m.hit ? !perm_ok : !bg_ok) begin
          next_s.fault      = 1'b1;
          next_s.fault_addr = i_acc_addr;
          // set wins over a same-cycle write-one-to-clear
          next_s.cause      = next_s.cause |
                              (i_acc_fetch ? 8'h01 : 8'h02);
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn)
      s <= '0;
    else
      s <= next_s;
  end

  logic kind_ordered;
  assign kind_ordered = (kind == mpu_pkg::mem_strong_type);

  sequence req_s;
    (i_read | i_write) && !s.ack;
  endsequence
  sequence ack_s;
    !o_waitrequest;
  endsequence

  bus_answer_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    req_s |=> ack_s) else $error("bus request not answered in one cycle");
  sel_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (i_write && !s.ack && i_address == `MPU_OFS_SELECT)
      |=> s.sel == $past(i_writedata[2:0])) else $error("select not stored");
  base_valid_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (i_write && !s.ack && i_address == `MPU_OFS_BASE && i_writedata[4])
      |=> s.sel == $past(i_writedata[2:0])) else $error("valid base ignored");
  no_access_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (i_acc_valid && s.unit_en && m.hit && m.access_permission == 3'h0)
      |=> o_fault) else $error("ap 000 access not faulted");
  ro_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (i_acc_valid && s.unit_en && m.hit && m.access_permission[2:1] == 2'h3
     && i_acc_write) |=> o_fault) else $error("read-only write not faulted");
  full_access_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (i_acc_valid && s.unit_en && m.hit && m.access_permission == 3'h3
     && !(i_acc_fetch && m.exec_never)) |=> !o_fault)
    else $error("full access faulted");
  unmatched_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (i_acc_valid && s.unit_en && !m.hit && !i_acc_priv) |=> o_fault)
    else $error("unmatched user access passed");
  cause_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (i_acc_valid && s.unit_en && m.hit && !perm_ok)
      |=> (o_fault && s.cause != 8'h0)) else $error("fault cause not recorded");
  disabled_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (i_acc_valid && !s.unit_en) |=> !o_fault) else $error("fault while off");
  strong_type_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (m.hit && s.region[m.number].type_extension == 3'h0 &&
     !s.region[m.number].cacheable && !s.region[m.number].bufferable)
      |-> kind_ordered) else $error("strongly ordered not decoded");
endmodule

// ---- logic/mpu_map.svh ----
// register map, field positions and reset values of the protection unit
// assumes a 32-bit avalon-mm slave decoding the low 12 address bits
`ifndef MPU_MAP_SVH
`define MPU_MAP_SVH
`define MPU_OFS_CTRL      12'hd94
`define MPU_OFS_SELECT    12'hd98
`define MPU_OFS_BASE      12'hd9c
`define MPU_OFS_ATTR      12'hda0
`define MPU_OFS_ALIAS_END 12'hdb8
`define MPU_OFS_FAULT     12'hd28
`define MPU_OFS_FADDR     12'hd34
`define MPU_REGIONS       8
`define MPU_BASE_VALID    4
`define MPU_CTRL_ENABLE   0
`define MPU_CTRL_BGND     2
`define MPU_RESET_WORD    32'h0000_0000
`define MPU_MIN_SUB_SIZE  5'h07
`endif

// ---- logic/mpu_pkg.sv ----
// types shared by the protection unit files
// assumes mpu_map.svh for the numeric constants
package mpu_pkg;
  typedef enum logic [2:0] {
    mem_strong_type, mem_device_type, mem_dev_nonshared_type,
    mem_normal_type, mem_reserved_type
  } mem_kind_type;
  typedef enum logic [1:0] {
    pol_noncache_type, pol_wb_alloc_type, pol_wt_type, pol_wb_type
  } cache_pol_type;
  typedef struct packed {
    logic [26:0] base;
    logic        enable;
    logic [4:0]  size;
    logic [7:0]  sub_mask;
    logic        exec_never;
    logic [2:0]  access_permission;
    logic [2:0]  type_extension;
    logic        shareable;
    logic        cacheable;
    logic        bufferable;
  } region_type;
  typedef struct packed {
    logic        hit;
    logic [2:0]  access_permission;
    logic        exec_never;
    logic [2:0]  number;
  } match_type;
endpackage

// ---- logic/mpu_check_if.sv ----
// carrier between the register file and the access checker
// assumes one clock domain
`timescale 1ns/1ps
interface mpu_check_if;
  mpu_pkg::region_type regions [8];
  logic                unit_enable;
  logic                bgnd_enable;
  modport regs  (output regions, output unit_enable, output bgnd_enable);
  modport check (input regions, input unit_enable, input bgnd_enable);
endinterface

// ---- logic/mpu_attr_decode.sv ----
// decodes memory type and cache policies of one attribute set
// assumes a purely combinational use by the checker
`timescale 1ns/1ps
module mpu_attr_decode (
  input  wire logic [2:0]            i_type_extension,
  input  wire logic                  i_cacheable,
  input  wire logic                  i_bufferable,
  input  wire logic                  i_shareable,
  output mpu_pkg::mem_kind_type      o_kind,
  output logic                       o_shared,
  output mpu_pkg::cache_pol_type     o_inner,
  output mpu_pkg::cache_pol_type     o_outer
);
  function automatic mpu_pkg::cache_pol_type pol(input logic [1:0] c);
    pol = mpu_pkg::cache_pol_type'(c);
  endfunction
  always_comb begin
    o_kind   = mpu_pkg::mem_reserved_type;
    o_shared = 1'b1;
    o_inner  = mpu_pkg::pol_noncache_type;
    o_outer  = mpu_pkg::pol_noncache_type;
    case ({i_type_extension, i_cacheable, i_bufferable})
      5'h00: o_kind = mpu_pkg::mem_strong_type;
      5'h01: o_kind = mpu_pkg::mem_device_type;
      5'h02, 5'h03: begin
        o_kind   = mpu_pkg::mem_normal_type;
        o_shared = i_shareable;
        o_inner  = i_bufferable ? pol(2'h1) : pol(2'h2);
        o_outer  = o_inner;
      end
      5'h04: begin
        o_kind   = mpu_pkg::mem_normal_type;
        o_shared = i_shareable;
      end
      5'h07: begin
        o_kind   = mpu_pkg::mem_normal_type;
        o_shared = i_shareable;
        o_inner  = pol(2'h1);
        o_outer  = pol(2'h1);
      end
      5'h08: begin
        o_kind   = mpu_pkg::mem_dev_nonshared_type;
        o_shared = 1'b0;
      end
      default: begin
        if (i_type_extension[2]) begin
          o_kind   = mpu_pkg::mem_normal_type;
          o_shared = i_shareable;
          o_outer  = pol(i_type_extension[1:0]);
          o_inner  = pol({i_cacheable, i_bufferable});
        end
      end
    endcase
  end
endmodule

// ---- logic/mpu_region_match.sv ----
// finds the highest numbered enabled region covering an address
// assumes region settings arrive through mpu_check_if
`timescale 1ns/1ps
`include "mpu_map.svh"
module mpu_region_match (
  mpu_check_if.check              bus,
  input  wire logic [31:0]        i_addr,
  output mpu_pkg::match_type      o_match
);
  function automatic logic covers(input mpu_pkg::region_type r,
                                  input logic [31:0] a);
    logic [31:0] mask;
    logic [2:0]  sub;
    mask = ~((32'h2 << r.size) - 32'h1);
    sub  = 3'(a >> (r.size - 5'h2));
    covers = r.enable && ((a & mask) == ({r.base, 5'h00} & mask));
    if (r.size >= `MPU_MIN_SUB_SIZE && r.sub_mask[sub])
      covers = 1'b0;
  endfunction
  always_comb begin
    o_match = '0;
    for (int i = 0; i < `MPU_REGIONS; i++) begin
      if (covers(bus.regions[i], i_addr)) begin
        o_match.hit               = 1'b1;
        o_match.access_permission = bus.regions[i].access_permission;
        o_match.exec_never        = bus.regions[i].exec_never;
        o_match.number            = 3'(i);
      end
    end
  end
endmodule

// ---- test/mpu_core_model.sv ----
// core-side model issuing access checks to the protection unit
// assumes one clock; drives after rising edges, waits for o_acc_done
`timescale 1ns/1ps
module mpu_core_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_acc_done,
  input  wire logic        i_fault,
  input  wire logic [2:0]  i_region,
  output logic             o_acc_valid,
  output logic [31:0]      o_acc_addr,
  output logic             o_acc_write,
  output logic             o_acc_fetch,
  output logic             o_acc_priv
);
  initial begin
    o_acc_valid = 1'b0;
    o_acc_addr  = 32'h0;
    o_acc_write = 1'b0;
    o_acc_fetch = 1'b0;
    o_acc_priv  = 1'b0;
  end
  // callers probe only once setup writes have completed
  task automatic probe(input logic [31:0] a, input logic w, f, p,
                       output logic flt, output logic [2:0] rn);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    o_acc_valid <= 1'b1;
    o_acc_addr  <= a;
    o_acc_write <= w;
    o_acc_fetch <= f;
    o_acc_priv  <= p;
    @(posedge i_sys_clk);
    o_acc_valid <= 1'b0;
    // stale address would hide a checker that ignores valid
    o_acc_addr  <= ~a;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (i_acc_done !== 1'b1 && n < 8);
    flt = i_fault;
    rn  = i_region;
  endtask
endmodule

// ---- test/mpu_region_checker_tb.sv ----
// self-checking bench for the protection unit and its attribute decoder
// assumes mpu_core_model on the access port, avalon-mm master tasks here
`timescale 1ns/1ps
module mpu_region_checker_tb;
  logic clk, rstn, rd, wr_en, done, fault;
  logic acc_valid, acc_write, acc_fetch, acc_priv, wreq;
  logic [11:0] addr;
  logic [31:0] wdata, rdata, acc_addr;
  logic [3:0]  be;
  logic [2:0]  region;
  int failures, num_checks;
  mpu_region_checker dut (
    .i_sys_clk(clk), .i_rstn(rstn), .i_address(addr), .i_read(rd),
    .i_write(wr_en), .i_writedata(wdata), .i_byteenable(be),
    .o_readdata(rdata), .o_waitrequest(wreq), .i_acc_valid(acc_valid),
    .i_acc_addr(acc_addr), .i_acc_write(acc_write),
    .i_acc_fetch(acc_fetch), .i_acc_priv(acc_priv), .o_acc_done(done),
    .o_fault(fault), .o_region(region));
  mpu_core_model core (
    .i_sys_clk(clk), .i_acc_done(done), .i_fault(fault),
    .i_region(region), .o_acc_valid(acc_valid), .o_acc_addr(acc_addr),
    .o_acc_write(acc_write), .o_acc_fetch(acc_fetch),
    .o_acc_priv(acc_priv));
  always #4 clk = ~clk;
  task automatic check(input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] b,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    rd    <= !w;
    wr_en <= w;
    addr  <= a;
    wdata <= d;
    be    <= b;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 16);
    q = rdata;
    rd    <= 1'b0;
    wr_en <= 1'b0;
    wdata <= ~d;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] b = 4'hf);
    logic [31:0] q;
    bus(1'b1, a, d, b, q);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] exp,
                    input logic [31:0] m = 32'hffff_ffff);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    check(q & m, exp);
  endtask
  task automatic acc(input logic [31:0] a, input logic w, f, p, ef,
                     input logic [2:0] er);
    logic flt;
    logic [2:0] rn;
    core.probe(a, w, f, p, flt, rn);
    check({31'h0, flt}, {31'h0, ef});
    check({29'h0, rn}, {29'h0, er});
  endtask
  function automatic logic [31:0] aw(input logic [2:0] ap,
      input logic [4:0] sz, input logic [7:0] m, input logic en);
    // small regions keep an empty mask
    return {5'h0, ap, 8'h0, m & {8{sz >= 5'h7}}, 2'h0, sz, en};
  endfunction
  function automatic logic allowed(input logic [2:0] ap, input logic p, w);
    case (ap)
      3'h1: return p;
      3'h2: return p | !w;
      3'h3: return 1'b1;
      3'h5: return p & !w;
      3'h6, 3'h7: return !w;
      default: return 1'b0;
    endcase
  endfunction
  function automatic mpu_pkg::mem_kind_type kind_of(input logic [2:0] t,
                                                    input logic [1:0] cb);
    if (t[2]) return mpu_pkg::mem_normal_type;
    case (t)
      3'h0: return cb == 2'h0 ? mpu_pkg::mem_strong_type :
                   cb == 2'h1 ? mpu_pkg::mem_device_type :
                   mpu_pkg::mem_normal_type;
      3'h1: return (cb == 2'h0 || cb == 2'h3) ? mpu_pkg::mem_normal_type :
                   mpu_pkg::mem_reserved_type;
      3'h2: return cb == 2'h0 ? mpu_pkg::mem_dev_nonshared_type :
                   mpu_pkg::mem_reserved_type;
      default: return mpu_pkg::mem_reserved_type;
    endcase
  endfunction
  task automatic t_reset();
    rc(12'hd94, 32'h0);
    rc(12'hd98, 32'h0);
    rc(12'hd00, 32'h0);
    acc(32'h2000_0000, 1'b1, 1'b0, 1'b0, 1'b0, 3'h0);
  endtask
  task automatic t_separate();
    wr(12'hd98, 32'h0);
    wr(12'hda0, aw(3'h3, 5'h9, 8'h0, 1'b0), 4'h3);
    wr(12'hd9c, 32'h2000_0000);
    wr(12'hda0, aw(3'h3, 5'h9, 8'h0, 1'b0), 4'hc);
    wr(12'hda0, aw(3'h3, 5'h9, 8'h0, 1'b1), 4'h3);
    wr(12'hd94, 32'h1);
    rc(12'hda0, aw(3'h3, 5'h9, 8'h0, 1'b1));
    acc(32'h2000_03fc, 1'b1, 1'b0, 1'b0, 1'b0, 3'h0);
  endtask
  task automatic t_perm();
    for (int ap = 0; ap < 8; ap++) begin
      wr(12'hda0, aw(ap[2:0], 5'h9, 8'h0, 1'b1));
      for (int i = 0; i < 4; i++) begin
        acc(32'h2000_0300, i[0], 1'b0, i[1],
            !allowed(ap[2:0], i[1], i[0]), 3'h0);
      end
    end
    wr(12'hd28, 32'hff);
    acc(32'h2000_0300, 1'b1, 1'b0, 1'b0, 1'b1, 3'h0);
    rc(12'hd28, 32'h2, 32'hff);
    wr(12'hd28, 32'h2);
    rc(12'hd28, 32'h0, 32'hff);
  endtask
  task automatic t_subregion();
    wr(12'hda0, aw(3'h3, 5'h9, 8'h0, 1'b1));
    wr(12'hd98, 32'h1);
    wr(12'hd9c, 32'h2000_0000);
    wr(12'hda0, aw(3'h0, 5'h7, 8'h01, 1'b1));
    acc(32'h2000_0004, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0);
    acc(32'h2000_0024, 1'b0, 1'b0, 1'b0, 1'b1, 3'h1);
    acc(32'h2000_00fc, 1'b0, 1'b0, 1'b1, 1'b1, 3'h1);
    acc(32'h2000_0100, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0);
  endtask
  task automatic t_alias();
    wr(12'hd98, 32'h4);
    wr(12'hda4, 32'h3000_0000);
    wr(12'hda8, aw(3'h3, 5'h7, 8'h0, 1'b1));
    acc(32'h3000_0010, 1'b1, 1'b0, 1'b0, 1'b0, 3'h5);
    wr(12'hd9c, 32'h3000_0016);
    wr(12'hda0, aw(3'h1, 5'h7, 8'h0, 1'b1));
    rc(12'hd98, 32'h6, 32'h7);
    acc(32'h3000_0010, 1'b0, 1'b0, 1'b0, 1'b1, 3'h6);
    wr(12'hd98, 32'h0);
    wr(12'hdb4, 32'h4000_0000);
    wr(12'hdb8, aw(3'h3, 5'h7, 8'h0, 1'b1));
    acc(32'h4000_00f0, 1'b1, 1'b0, 1'b0, 1'b0, 3'h3);
  endtask
  task automatic t_bgnd();
    acc(32'h6000_0000, 1'b0, 1'b0, 1'b1, 1'b1, 3'h0);
    wr(12'hd94, 32'h5);
    acc(32'h6000_0000, 1'b1, 1'b0, 1'b1, 1'b0, 3'h0);
    wr(12'hd28, 32'hff);
    acc(32'h6000_0000, 1'b0, 1'b1, 1'b0, 1'b1, 3'h0);
    rc(12'hd28, 32'h1, 32'hff);
  endtask
  task automatic t_decode();
    wr(12'hd98, 32'h0);
    for (int i = 0; i < 64; i++) begin
      wr(12'hda0, {10'h0, i[5:3], i[0], i[2], i[1], 16'h0}, 4'h4);
      // core address hits nothing, so region 0 feeds the decoder
      check(32'(dut.kind), 32'(kind_of(i[5:3], i[2:1])));
      if (i[5]) begin
        check(32'(dut.u_attr.o_inner), {30'h0, i[2:1]});
        check(32'(dut.u_attr.o_outer), {30'h0, i[4:3]});
      end
    end
  endtask
  task automatic tally_and_finish();
    if (failures == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    rd = 1'b0;
    wr_en = 1'b0;
    addr = 12'h0;
    wdata = 32'h0;
    be = 4'hf;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_separate();
    t_perm();
    t_subregion();
    t_alias();
    t_bgnd();
    t_decode();
    tally_and_finish();
  end
endmodule
